// File: interference_detector.sv
// Interference detector core with AHB-Lite register slave
// Overview of operation
// RL1: Rate change too fast for a level change flags interference.
// RL2: Rate above highest plausible rate flags interference.
// RL3: Rate below two pulses per second flags interference.
// RL4: Detection freezes level, drops second relay, sets status.
// RL5: Criteria are evaluated only while the enable bit is one.
// RL6: Frozen level is held for the operator time window in seconds.
// RL7: Normal measurement resumes twenty seconds after the window.
// RL8: Emptying time judges whether a rate change is level-driven.
// RL9: Responsiveness defaults to zero, max ten, larger means fewer trips.
// RL10: Operator sets responsiveness near ten times wave height over range.
// RL11: Warning mode drops only the second relay.
// RL12: Alarm mode also drops alarm relay and forces alarm current.
// RL13: Status reads one while a routine runs; a write cancels it.
// RL14: Detected events are counted; a write clears the counter.
// RL15: In a cascade only the master acts on the interference relay.
// RL16: Highest detector temperature is held and readable.
// RL17: Operator keeps reference sensitivity between thirty and eighty percent.
// RL18: Conditions persisting at window end post the overrun code.
// RL19: Detection in warning mode posts the warning code.
// RL20: Detection in alarm mode posts the alarm code.
// RL21: Rate threshold comes from emptying time and responsiveness.
`timescale 1ns/1ps
module interference_detector
    import interference_pkg::*;
#(
    parameter int GATE_CYCLES = SAMPLE_CYCLES
) (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               reset_n,
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic [31:0]             hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    // Detector side
    input  wire logic               detector_pulse,
    input  wire logic signed [15:0] detector_temp,
    // Measurement path
    input  wire logic [15:0]        measured_level,
    input  wire logic [15:0]        measured_current,
    output logic [15:0]             displayed_level,
    output logic [15:0]             current_out,
    // Relays
    input  wire logic               limit_relay_demand,
    input  wire logic               alarm_relay_demand,
    output logic                    second_limit_relay,
    output logic                    alarm_relay
);
    logic        rst_sync1_reg, rst_n_reg;
    logic [2:0]  pin_sync_reg;
    logic        pulse_level_reg;
    det_state_t  state_reg;
    logic        ctrl_enable_reg, ctrl_fault_reg, ctrl_slave_reg;
    logic [15:0] hold_time_window_reg, vessel_empty_time_reg;
    logic [3:0]  responsiveness_factor_reg;
    logic [15:0] rate_hi_reg, rate_lo_reg, alarm_current_setting_reg;
    logic [15:0] detection_event_counter_reg, error_code_reg;
    logic signed [15:0] peak_detector_temperature_reg;
    logic [15:0] prev_rate_reg, sec_cnt_reg, displayed_level_reg;
    logic        prev_valid_reg;
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic [15:0] delta, span;
    logic [31:0] change_lhs, change_rhs;
    logic        crit_change, crit_high, crit_low, criteria, det_fire;
    logic        active, addr_phase, wr_commit, cancel_req, clear_cnt, clear_err;
    logic        sec_tick, window_end, settle_end;

    rate_if rif ();

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync1_reg <= 1'b0;
            rst_n_reg     <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_n_reg     <= rst_sync1_reg;
        end
    end

    // Detector pin: three flops, a change counts once flops two and three agree
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pin_sync_reg    <= '0;
            pulse_level_reg <= 1'b0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], detector_pulse};
            if (pin_sync_reg[1] == pin_sync_reg[2]) begin
                pulse_level_reg <= pin_sync_reg[2];
            end
        end
    end

    assign rif.pulse_rise = (pin_sync_reg[1] == pin_sync_reg[2]) && pin_sync_reg[2] && !pulse_level_reg;

    rate_meter #(.GATE_CYCLES(GATE_CYCLES)) u_rate_meter (
        .core_clk (core_clk),
        .rst_n    (rst_n_reg),
        .rif      (rif.meter)
    );

    assign sec_tick = rif.tick;
    assign active   = (state_reg != ST_IDLE);

    // Plausibility checks on each fresh sample
    assign crit_high = (rif.rate > rate_hi_reg);  // [RL2]
    assign crit_low  = (rif.rate < RATE_MIN_PPS);  // [RL3]
    assign delta = (rif.rate >= prev_rate_reg) ? rif.rate - prev_rate_reg : prev_rate_reg - rif.rate;
    assign span  = (rate_hi_reg > rate_lo_reg) ? rate_hi_reg - rate_lo_reg : 16'h0000;
    // Level can move the rate by at most span per emptying time; cross-multiplied to avoid a divider
    assign change_lhs  = delta * vessel_empty_time_reg;  // [RL8]
    assign change_rhs  = span * {12'h000, responsiveness_factor_reg + 4'h1};  // [RL9] [RL21]
    assign crit_change = prev_valid_reg && (change_lhs > change_rhs);  // [RL1]
    assign criteria    = ctrl_enable_reg && (crit_change || crit_high || crit_low);  // [RL5]
    // Slave does not run its own routine; the master's parameters govern
    assign det_fire    = sec_tick && criteria && !ctrl_slave_reg && (state_reg == ST_IDLE);  // [RL15]

    assign window_end = sec_tick && (sec_cnt_reg + 16'h0001 >= hold_time_window_reg);
    assign settle_end = sec_tick && (sec_cnt_reg + 16'h0001 >= RESUME_DELAY_S);

    // Previous sample for the rate-of-change test
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            prev_rate_reg  <= '0;
            prev_valid_reg <= 1'b0;
        end else if (sec_tick) begin
            prev_rate_reg  <= rif.rate;
            prev_valid_reg <= 1'b1;
        end
    end

    // Bus decode; zero wait states, always OKAY
    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_commit  = wr_pend_reg && hready;
    assign cancel_req = wr_commit && (wr_addr_reg == STATUS_OFS);  // [RL13]
    assign clear_cnt  = wr_commit && (wr_addr_reg == COUNTER_OFS);  // [RL14]
    assign clear_err  = wr_commit && (wr_addr_reg == ERROR_OFS);
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;

    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else if (hready) begin
            wr_pend_reg <= addr_phase && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    // Read data registered during the address phase; unmapped reads return zero
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            hrdata <= '0;
        end else if (addr_phase && !hwrite) begin
            unique case (haddr[7:0])
                CTRL_OFS:       hrdata <= {29'h0000_0000, ctrl_slave_reg, ctrl_fault_reg, ctrl_enable_reg};
                WINDOW_OFS:     hrdata <= {16'h0000, hold_time_window_reg};
                EMPTY_TIME_OFS: hrdata <= {16'h0000, vessel_empty_time_reg};
                RESP_OFS:       hrdata <= {28'h000_0000, responsiveness_factor_reg};
                STATUS_OFS:     hrdata <= {31'h0000_0000, active};  // [RL13]
                COUNTER_OFS:    hrdata <= {16'h0000, detection_event_counter_reg};
                RATE_HI_OFS:    hrdata <= {16'h0000, rate_hi_reg};
                RATE_LO_OFS:    hrdata <= {16'h0000, rate_lo_reg};
                ALARM_CUR_OFS:  hrdata <= {16'h0000, alarm_current_setting_reg};
                ERROR_OFS:      hrdata <= {16'h0000, error_code_reg};
                PEAK_TEMP_OFS:  hrdata <= {16'h0000, peak_detector_temperature_reg};
                RATE_OFS:       hrdata <= {16'h0000, rif.rate};
                default:        hrdata <= '0;
            endcase
        end
    end

    // Software-written parameters
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ctrl_enable_reg           <= 1'b0;
            ctrl_fault_reg            <= 1'b0;
            ctrl_slave_reg            <= 1'b0;
            hold_time_window_reg      <= WINDOW_RST;
            vessel_empty_time_reg     <= EMPTY_TIME_RST;
            responsiveness_factor_reg <= '0;  // [RL9]
            rate_hi_reg               <= RATE_HI_RST;
            rate_lo_reg               <= RATE_LO_RST;
            alarm_current_setting_reg <= ALARM_CUR_RST;
        end else if (wr_commit) begin
            unique case (wr_addr_reg)
                CTRL_OFS: begin
                    ctrl_enable_reg <= hwdata[CTRL_ENABLE_BIT];  // [RL5]
                    ctrl_fault_reg  <= hwdata[CTRL_FAULT_BIT];
                    ctrl_slave_reg  <= hwdata[CTRL_SLAVE_BIT];
                end
                WINDOW_OFS:     hold_time_window_reg  <= hwdata[15:0];  // [RL6]
                EMPTY_TIME_OFS: vessel_empty_time_reg <= hwdata[15:0];  // [RL8]
                // Values above the permitted maximum are clamped
                RESP_OFS: responsiveness_factor_reg <= (hwdata[31:4] != '0 || hwdata[3:0] > RESP_MAX)
                                                       ? RESP_MAX : hwdata[3:0];  // [RL9]
                RATE_HI_OFS:    rate_hi_reg               <= hwdata[15:0];
                RATE_LO_OFS:    rate_lo_reg               <= hwdata[15:0];
                ALARM_CUR_OFS:  alarm_current_setting_reg <= hwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // Detection routine: hold for the window, then settle twenty seconds
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg   <= ST_IDLE;
            sec_cnt_reg <= '0;
        end else if (cancel_req && active) begin
            state_reg   <= ST_IDLE;  // [RL13]
            sec_cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    sec_cnt_reg <= '0;
                    if (det_fire) begin
                        state_reg <= ST_HOLD;  // [RL4]
                    end
                end
                ST_HOLD: begin
                    if (window_end) begin
                        state_reg   <= ST_SETTLE;  // [RL6]
                        sec_cnt_reg <= '0;
                    end else if (sec_tick) begin
                        sec_cnt_reg <= sec_cnt_reg + 16'h0001;
                    end
                end
                ST_SETTLE: begin
                    if (settle_end) begin
                        state_reg   <= ST_IDLE;  // [RL7]
                        sec_cnt_reg <= '0;
                    end else if (sec_tick) begin
                        sec_cnt_reg <= sec_cnt_reg + 16'h0001;
                    end
                end
            endcase
        end
    end

    // Event counter; a detection in the clearing cycle still counts
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            detection_event_counter_reg <= '0;
        end else if (det_fire) begin
            detection_event_counter_reg <= clear_cnt ? 16'h0001 : detection_event_counter_reg + 16'h0001;  // [RL14]
        end else if (clear_cnt) begin
            detection_event_counter_reg <= '0;  // [RL14]
        end
    end

    // Diagnostic code; new code wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            error_code_reg <= CODE_NONE;
        end else if (det_fire) begin
            error_code_reg <= ctrl_fault_reg ? CODE_ALARM : CODE_WARNING;  // [RL19] [RL20]
        end else if (state_reg == ST_HOLD && window_end && criteria) begin
            error_code_reg <= CODE_OVERRUN;  // [RL18]
        end else if (clear_err) begin
            error_code_reg <= CODE_NONE;
        end
    end

    // Peak temperature hold
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            peak_detector_temperature_reg <= TEMP_RST;
        end else if (detector_temp > peak_detector_temperature_reg) begin
            peak_detector_temperature_reg <= detector_temp;  // [RL16]
        end
    end

    // Displayed level frozen while a routine runs, including the settle time
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            displayed_level_reg <= '0;
        end else if (!active && !det_fire) begin
            displayed_level_reg <= measured_level;  // [RL4] [RL6]
        end
    end

    assign displayed_level = displayed_level_reg;

    // Relay and current outputs, registered; relays are high when energised
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            second_limit_relay <= 1'b0;
            alarm_relay        <= 1'b0;
            current_out        <= '0;
        end else begin
            second_limit_relay <= limit_relay_demand && !(active && !ctrl_slave_reg);  // [RL4] [RL15]
            alarm_relay        <= alarm_relay_demand && !(active && ctrl_fault_reg);  // [RL11] [RL12]
            current_out        <= (active && ctrl_fault_reg) ? alarm_current_setting_reg
                                                             : measured_current;  // [RL11] [RL12]
        end
    end

    // Checks
    property p_fire_starts;
        @(posedge core_clk) disable iff (!rst_n_reg)
        det_fire && !cancel_req |=> state_reg == ST_HOLD;
    endproperty
    fire_starts_a: assert property (p_fire_starts) else $error("detection did not start hold");  // [RL4]

    disabled_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        !ctrl_enable_reg |-> !det_fire) else $error("detection while disabled");  // [RL5]

    low_rate_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        sec_tick && ctrl_enable_reg && !ctrl_slave_reg && state_reg == ST_IDLE && rif.rate < RATE_MIN_PPS
        |-> ##1 active ##1 second_limit_relay == 1'b0) else $error("low rate not flagged");  // [RL3]

    high_rate_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        sec_tick && ctrl_enable_reg && !ctrl_slave_reg && state_reg == ST_IDLE && rif.rate > rate_hi_reg
        |=> active) else $error("high rate not flagged");  // [RL2]

    freeze_level_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        active && $past(active) |-> $stable(displayed_level)) else $error("level moved while held");  // [RL6]

    warn_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        active && !ctrl_fault_reg && $stable(ctrl_fault_reg) |=> alarm_relay == $past(alarm_relay_demand)
        && current_out == $past(measured_current)) else $error("warning mode touched alarm path");  // [RL11]

    alarm_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        active && ctrl_fault_reg |=> !alarm_relay && current_out == $past(alarm_current_setting_reg))
        else $error("alarm mode outputs wrong");  // [RL12]

    count_up_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        det_fire && !clear_cnt |=> detection_event_counter_reg == $past(detection_event_counter_reg) + 16'h0001)
        else $error("event not counted");  // [RL14]

    cancel_now_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        cancel_req && active |=> state_reg == ST_IDLE) else $error("cancel ignored");  // [RL13]

    settle_twenty_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        state_reg == ST_HOLD && window_end && !cancel_req |=> state_reg == ST_SETTLE && sec_cnt_reg == 16'h0000)
        else $error("settle period not started");  // [RL7]

    warn_code_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        det_fire |=> error_code_reg == ($past(ctrl_fault_reg) ? CODE_ALARM : CODE_WARNING))
        else $error("wrong detection code");  // [RL19] [RL20]

    peak_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        detector_temp > peak_detector_temperature_reg |=> peak_detector_temperature_reg == $past(detector_temp))
        else $error("peak temperature not captured");  // [RL16]

    cover_fire_c:    cover property (@(posedge core_clk) disable iff (!rst_n_reg) det_fire);
    cover_resume_c:  cover property (@(posedge core_clk) disable iff (!rst_n_reg)
        state_reg == ST_SETTLE ##1 state_reg == ST_IDLE);
    cover_overrun_c: cover property (@(posedge core_clk) disable iff (!rst_n_reg)
        state_reg == ST_HOLD && window_end && criteria);
    cover_cancel_c:  cover property (@(posedge core_clk) disable iff (!rst_n_reg) cancel_req && active);
endmodule : interference_detector

// File: interference_pkg.sv
// Constants, register map and state encodings for the interference detector
package interference_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS   = 5;
    localparam int SAMPLE_TIME_MS  = 1000;
    localparam int SAMPLE_CYCLES   = SAMPLE_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int GATE_W          = 28;
    localparam logic [15:0] RESUME_DELAY_S = 16'h0014;
    localparam logic [15:0] RATE_MIN_PPS   = 16'h0002;
    localparam logic [3:0]  RESP_MAX       = 4'ha;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS       = 8'h00;
    localparam logic [7:0] WINDOW_OFS     = 8'h04;
    localparam logic [7:0] EMPTY_TIME_OFS = 8'h08;
    localparam logic [7:0] RESP_OFS       = 8'h0c;
    localparam logic [7:0] STATUS_OFS     = 8'h10;
    localparam logic [7:0] COUNTER_OFS    = 8'h14;
    localparam logic [7:0] RATE_HI_OFS    = 8'h18;
    localparam logic [7:0] RATE_LO_OFS    = 8'h1c;
    localparam logic [7:0] ALARM_CUR_OFS  = 8'h20;
    localparam logic [7:0] ERROR_OFS      = 8'h24;
    localparam logic [7:0] PEAK_TEMP_OFS  = 8'h28;
    localparam logic [7:0] RATE_OFS       = 8'h2c;

    // Control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_FAULT_BIT  = 1;
    localparam int CTRL_SLAVE_BIT  = 2;

    // Reset values
    localparam logic [15:0] WINDOW_RST     = 16'h0168;
    localparam logic [15:0] EMPTY_TIME_RST = 16'h003c;
    localparam logic [15:0] RATE_HI_RST    = 16'hffff;
    localparam logic [15:0] RATE_LO_RST    = 16'h0000;
    localparam logic [15:0] ALARM_CUR_RST  = 16'h0000;
    localparam logic signed [15:0] TEMP_RST = 16'sh8000;

    // Diagnostic codes
    localparam logic [15:0] CODE_NONE      = 16'h0000;
    localparam logic [15:0] CODE_OVERRUN   = 16'h0210;
    localparam logic [15:0] CODE_WARNING   = 16'h0211;
    localparam logic [15:0] CODE_ALARM     = 16'h0212;

    // Detection routine states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_HOLD   = 3'b010,
        ST_SETTLE = 3'b100
    } det_state_t;

endpackage : interference_pkg

// File: pulse_source.sv
// Detector pulse stream model for the interference bench
`timescale 1ns/1ps
module pulse_source (
    // Clock and pacing
    input  wire logic       core_clk,
    input  wire logic [7:0] half_period,
    // Pulse stream
    output logic            pulse
);
    logic [7:0] cnt;
    initial begin
        cnt = 8'h00;
        pulse = 1'b0;
    end
    // Steady pacing stands for a detector whose sensitivity stays in range
    // Zero pacing stops the stream, pin idles low like a dead detector
    always @(posedge core_clk) begin
        cnt <= (cnt >= half_period) ? 8'h01 : cnt + 8'h01;
        if (half_period == 8'h00) pulse <= 1'b0;
        else if (cnt >= half_period) pulse <= ~pulse;
    end
endmodule : pulse_source

// File: radiography_interference_detector_bench.sv
// Self-checking bench for the interference detector
`timescale 1ns/1ps
module radiography_interference_detector_bench;
    import interference_pkg::*;
    localparam int GATE = 200;
    logic               core_clk = 0, reset_n = 0, hwrite = 0, rd_phase = 0, alm_dem = 1;
    logic        [31:0] haddr = 0, hwdata = 0, hrdata, lfsr = 32'h0000_1ba8;
    logic        [1:0]  htrans = 0;
    logic        [7:0]  half_period = 0;
    logic        [15:0] measured_level = 0, measured_current = 0, lvl, cur;
    logic        [15:0] displayed_level, current_out;
    logic signed [15:0] detector_temp = 0, peak = 0;
    logic               hreadyout, hresp, detector_pulse, second_limit_relay, alarm_relay;
    logic        [31:0] rd_q[$];
    logic        [33:0] pin_q[$];
    int                 num_errors = 0, comparisons = 0;

    always #2.5 core_clk = ~core_clk;

    interference_detector #(.GATE_CYCLES(GATE)) u_dut (.core_clk, .reset_n, .hsel(1'b1), .haddr, .htrans,
        .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .detector_pulse,
        .detector_temp, .measured_level, .measured_current, .displayed_level, .current_out,
        .limit_relay_demand(1'b1), .alarm_relay_demand(alm_dem), .second_limit_relay, .alarm_relay);
    pulse_source u_src (.core_clk, .half_period, .pulse(detector_pulse));

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    task conclude;
        if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    task chk_word(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: read %h, expected %h", $time, g, e);
        end
    endtask : chk_word
    task chk_pins(input logic [34:0] e, input logic [34:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: outputs %h, expected %h", $time, g, e);
        end
    endtask : chk_pins
    // One AHB single transfer; waits on hready, never on a fixed count
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
    endtask : bus
    task rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask : rd
    task pins(input logic [33:0] e);
        pin_q.push_back(e);
        @(posedge core_clk);
    endtask : pins
    task gates(input int n);
        repeat (n * GATE) @(posedge core_clk);
    endtask : gates

    // Watchers pop the oldest note when a read data phase or pin check comes due
    always @(posedge core_clk) begin
        if (rd_phase) chk_word(rd_q.pop_front(), hrdata);
        rd_phase <= htrans[1] && !hwrite && hreadyout;
    end
    always @(negedge core_clk) begin
        if (pin_q.size() != 0)
            chk_pins({1'b0, pin_q.pop_front()}, {hresp, second_limit_relay, alarm_relay, current_out, displayed_level});
    end
    // Hang guard sized well past the longest expected run
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        // Random temperatures; bench keeps its own peak
        repeat (8) begin
            lfsr = lfsr_next(lfsr);
            detector_temp <= lfsr[15:0];
            if ($signed(lfsr[15:0]) > peak) peak = lfsr[15:0];
            @(posedge core_clk);
        end
        lvl = lfsr[31:16];
        cur = lfsr[15:0];
        measured_level <= lvl;
        measured_current <= cur;
        rd(PEAK_TEMP_OFS, {16'h0000, peak});
        rd(WINDOW_OFS, 32'h0000_0168);
        rd(8'h30, 32'h0000_0000);
        rd(RESP_OFS, 32'h0000_0000);
        bus(1'b1, RESP_OFS, 32'h0000_000f);
        rd(RESP_OFS, {28'h000_0000, RESP_MAX});
        bus(1'b1, WINDOW_OFS, 32'h0000_0002);
        gates(3);
        rd(STATUS_OFS, 32'h0000_0000);
        half_period <= 8'h04;
        gates(3);
        bus(1'b1, CTRL_OFS, 32'h0000_0001);
        gates(2);
        rd(STATUS_OFS, 32'h0000_0000);
        // Dead stream trips warning mode
        half_period <= 8'h00;
        gates(3);
        rd(STATUS_OFS, 32'h0000_0001);
        rd(COUNTER_OFS, 32'h0000_0001);
        rd(ERROR_OFS, {16'h0000, CODE_WARNING});
        measured_level <= ~lvl;
        alm_dem <= 1'b0;
        pins({2'b01, cur, lvl});
        pins({2'b00, cur, lvl});
        alm_dem <= 1'b1;
        half_period <= 8'h04;
        gates(2);
        bus(1'b1, STATUS_OFS, 32'h0000_0000);
        rd(STATUS_OFS, 32'h0000_0000);
        pins({2'b11, cur, ~lvl});
        bus(1'b1, COUNTER_OFS, 32'h0000_0000);
        rd(COUNTER_OFS, 32'h0000_0000);
        // Alarm mode, rate above the plausible ceiling
        bus(1'b1, ALARM_CUR_OFS, 32'h0000_1234);
        bus(1'b1, CTRL_OFS, 32'h0000_0003);
        bus(1'b1, RATE_HI_OFS, 32'h0000_000a);
        gates(2);
        rd(ERROR_OFS, {16'h0000, CODE_ALARM});
        pins({2'b00, 16'h1234, ~lvl});
        gates(4);
        rd(ERROR_OFS, {16'h0000, CODE_OVERRUN});
        bus(1'b1, RATE_HI_OFS, 32'h0000_ffff);
        gates(14);
        rd(STATUS_OFS, 32'h0000_0001);
        gates(4);
        rd(STATUS_OFS, 32'h0000_0000);
        // Cascade slave ignores a dead stream
        bus(1'b1, CTRL_OFS, 32'h0000_0005);
        half_period <= 8'h00;
        gates(3);
        rd(STATUS_OFS, 32'h0000_0000);
        pins({2'b11, cur, ~lvl});
        // Sudden rate step with a long emptying time trips the change test alone
        half_period <= 8'h04;
        bus(1'b1, EMPTY_TIME_OFS, 32'h0000_0100);
        bus(1'b1, RATE_HI_OFS, 32'h0000_0040);
        gates(3);
        bus(1'b1, CTRL_OFS, 32'h0000_0001);
        half_period <= 8'h03;
        gates(2);
        rd(STATUS_OFS, 32'h0000_0001);
        conclude();
    end
endmodule : radiography_interference_detector_bench

// File: rate_if.sv
// Pulse-rate carrier between the rate meter and the detector core
`timescale 1ns/1ps
interface rate_if;
    logic        pulse_rise;
    logic [15:0] rate;
    logic        tick;

    modport meter (input pulse_rise, output rate, output tick);
    modport user  (output pulse_rise, input rate, input tick);
endinterface : rate_if

// File: rate_meter.sv
// Gated pulse counter producing one rate sample per gate interval
`timescale 1ns/1ps
module rate_meter
    import interference_pkg::*;
#(
    parameter int GATE_CYCLES = SAMPLE_CYCLES
) (
    // Clock and reset
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    // Rate carrier
    rate_if.meter       rif
);
    logic [GATE_W-1:0] gate_reg;
    logic [15:0]       acc_reg;
    logic              gate_end;

    assign gate_end = (gate_reg == GATE_W'(GATE_CYCLES - 1));

    // Gate timer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_reg <= '0;
        end else begin
            gate_reg <= gate_end ? '0 : gate_reg + 1'b1;
        end
    end

    // Pulse accumulator, saturates rather than wrapping
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= '0;
        end else if (gate_end) begin
            acc_reg <= {15'h0000, rif.pulse_rise};
        end else if (rif.pulse_rise && acc_reg != 16'hffff) begin
            acc_reg <= acc_reg + 16'h0001;
        end
    end

    // Rate sample and tick, both registered
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rif.rate <= '0;
            rif.tick <= 1'b0;
        end else begin
            rif.tick <= gate_end;
            if (gate_end) begin
                rif.rate <= acc_reg;
            end
        end
    end
endmodule : rate_meter
